// File: hw/oscc_pkg.sv
// Package of offsets, field positions, reset values and cycle counts for the oscillator control block.
package oscc_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [3:0] OSCC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] OSCC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] OSCC_ADDR_TUNING = 4'h8;
  localparam logic [3:0] OSCC_ADDR_FAIL = 4'hC;

  // Control register fields.
  localparam int OSCC_CTL_CONFIG_PLL_FORCE_BIT = 7;
  localparam int OSCC_CTL_IFS_LSB = 3;
  localparam int OSCC_CTL_SCS_LSB = 0;
  localparam logic [7:0] OSCC_CTL_RESET = 8'h38;
  localparam logic [7:0] OSCC_CTL_WMASK = 8'hFB;

  // Tuning register fields.
  localparam logic [7:0] OSCC_TUNE_WMASK = 8'h3F;
  localparam logic [7:0] OSCC_TUNE_RESET = 8'h00;

  // Fail register fields: bit 0 is the fail flag, bit 1 the fail interrupt enable.
  localparam int OSCC_FAIL_FLAG_BIT = 0;
  localparam int OSCC_FAIL_IE_BIT = 1;

  // Status register field positions.
  localparam int OSCC_ST_SECONDARY_OSC_READY = 7;
  localparam int OSCC_ST_PLL_READY_FLAG = 6;
  localparam int OSCC_ST_STARTUP_TIMER_STATUS = 5;
  localparam int OSCC_ST_HFR = 4;
  localparam int OSCC_ST_HFL = 3;
  localparam int OSCC_ST_MFR = 2;
  localparam int OSCC_ST_LFR = 1;
  localparam int OSCC_ST_HFS = 0;

  // Start-up timer length in external oscillations.
  localparam int OSCC_OST_COUNT = 1024;
  localparam logic [10:0] OSCC_OST_LAST = 11'h03FF;

  // Clock source selector codes.
  localparam logic [2:0] OSCC_SRC_CONFIG = 3'h0;
  localparam logic [2:0] OSCC_SRC_SECONDARY = 3'h1;
  localparam logic [2:0] OSCC_SRC_HF = 3'h2;
  localparam logic [2:0] OSCC_SRC_MF = 3'h3;
  localparam logic [2:0] OSCC_SRC_LF = 3'h4;

  // AXI responses.
  localparam logic [1:0] OSCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OSCC_RESP_SLVERR = 2'h2;

endpackage

// File: hw/oscc_freq_map.sv
// Frequency decoder: internal select code to source and divide code.
`timescale 1ns/10ps
module oscc_freq_map
(
  // Select inputs.
  input wire logic [3:0] ifs,
  input wire logic pll_on,
  // Decoded outputs.
  output logic [2:0] src,
  output logic [3:0] div_log2,
  output logic pll_32m
);

  // Divide exponent relative to 16 MHz HF or 500 kHz MF; LF is undivided.
  always_comb
  begin
    pll_32m = 1'b0;
    div_log2 = 4'h0;
    src = oscc_pkg::OSCC_SRC_LF;
    if (ifs[3])
    begin
      src = oscc_pkg::OSCC_SRC_HF;
      div_log2 = 4'(4'h7 - {1'b0, ifs[2:0]});
      pll_32m = (ifs == 4'hE) && pll_on;
    end
    else if (ifs[2])
    begin
      src = oscc_pkg::OSCC_SRC_MF;
      div_log2 = 4'(4'h3 - {2'b00, ifs[1:0]});
    end
    else if (ifs == 4'h3)
    begin
      src = oscc_pkg::OSCC_SRC_HF;
      div_log2 = 4'h9;
    end
    else if (ifs == 4'h2)
    begin
      src = oscc_pkg::OSCC_SRC_MF;
      div_log2 = 4'h4;
    end
  end

endmodule // oscc_freq_map

// File: hw/oscc_ost.sv
// Oscillator start-up timer counting external oscillation ticks.
`timescale 1ns/10ps
module oscc_ost
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Control.
  input wire logic restart,
  input wire logic ext_tick,
  // Status.
  output logic done
);

  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // Count ticks until the last one, then hold done.
  assign done_nxt = restart ? 1'b0 : (done_r | (ext_tick && cnt_r == oscc_pkg::OSCC_OST_LAST));
  assign cnt_nxt = (restart || done_r) ? 11'h000 : (ext_tick ? 11'(cnt_r + 11'h001) : cnt_r);
  assign done = done_r;

  // Timer state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_r <= 11'h000;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

endmodule // oscc_ost

// File: hw/oscc_ctrl.sv
// Oscillator control and status block with AXI4-Lite register slave.
//
// How it works
// R1: Config PLL force bit keeps the 4x PLL on, ignoring the software enable.
// R2: Without force, the software PLL enable bit turns the 4x PLL on and off.
// R3: Select codes 1111 down to 1000 give 16 MHz down to 125 kHz HF.
// R4: Codes 0111-0100 give MF 500-62.5 kHz; 0011 HF, 0010 MF, 000x LF.
// R5: Code 1110 with software PLL enable gives a 32 MHz clock.
// R6: Clock select 1x internal, 01 secondary, 00 config-word source.
// R7: Control bit 2 reads zero and ignores writes.
// R8: Secondary ready reads its oscillator while timer enable set, else reads 1.
// R9: PLL ready flag shows the 4x PLL ready condition.
// R10: Start-up status reads 1 on the config-word clock, 0 on internal.
// R11: HF ready flag shows HF internal oscillator readiness.
// R12: HF locked flag is 1 only while HF is within 2 percent.
// R13: MF ready flag shows MF internal oscillator readiness.
// R14: LF ready flag shows LF internal oscillator readiness.
// R15: HF stable flag is 1 only while HF is within 0.5 percent.
// R16: Six-bit signed trim, zero factory value, 011111 max, 100000 min.
// R17: Status register is read-only and tracks hardware continuously.
// R18: External clock failure switches to internal and sets fail flag; interrupt if enabled.
// R19: After failure the internal source follows the frequency select field.
// R20: Crystal modes wait 1024 oscillations before the external clock is used.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module oscc_ctrl
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // AXI4-Lite write address channel.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration word inputs.
  input wire logic config_pll_force,
  input wire logic config_crystal_mode,
  input wire logic config_failsafe_en,
  // Oscillator condition inputs.
  input wire logic timer_osc_enable,
  input wire logic secondary_osc_ready,
  input wire logic pll_locked,
  input wire logic high_freq_osc_ready,
  input wire logic high_freq_within_2pct,
  input wire logic high_freq_within_half_pct,
  input wire logic mid_freq_osc_ready,
  input wire logic low_freq_osc_ready,
  input wire logic ext_osc_tick,
  input wire logic ext_clock_failed,
  // Controls toward the oscillator module.
  output logic pll_enable,
  output logic [2:0] clock_source,
  output logic [3:0] clock_div_log2,
  output logic pll_32m_select,
  output logic [5:0] freq_trim,
  output logic osc_fail_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [7:0] tune_r;
  logic [7:0] tune_nxt;
  logic fail_flag_r;
  logic fail_flag_nxt;
  logic fail_ie_r;
  logic fail_ie_nxt;
  logic failsafe_r;
  logic failsafe_nxt;

  // Field views of the control register.
  wire logic software_pll_enable = ctl_r[oscc_pkg::OSCC_CTL_CONFIG_PLL_FORCE_BIT];
  wire logic [3:0] internal_freq_select = ctl_r[oscc_pkg::OSCC_CTL_IFS_LSB +: 4];
  wire logic [1:0] system_clock_select = ctl_r[oscc_pkg::OSCC_CTL_SCS_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data latched in either order.

  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [3:0] aw_addr_r;
  logic [3:0] aw_addr_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic [3:0] wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire logic [7:0] wr_byte = w_hold_r ? w_data_r[7:0] : s_axi_wdata[7:0];
  wire logic wr_lane0 = w_hold_r ? w_strb_r[0] : s_axi_wstrb[0];
  wire logic wr_have_aw = aw_hold_r || aw_take;
  wire logic wr_have_w = w_hold_r || w_take;
  wire logic wr_fire = wr_have_aw && wr_have_w && !bvalid_r;
  wire logic wr_en = wr_fire && wr_lane0;

  // Channels stay open until captured; a pending response blocks new ones.
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;

  // Decode of the write target.
  wire logic wr_ctl = wr_addr == oscc_pkg::OSCC_ADDR_CONTROL;
  wire logic wr_sts = wr_addr == oscc_pkg::OSCC_ADDR_STATUS;
  wire logic wr_tune = wr_addr == oscc_pkg::OSCC_ADDR_TUNING;
  wire logic wr_fail = wr_addr == oscc_pkg::OSCC_ADDR_FAIL;
  wire logic wr_mapped = wr_ctl || wr_sts || wr_tune || wr_fail;

  // Holding registers and response next values.
  assign aw_hold_nxt = wr_fire ? 1'b0 : (aw_hold_r || aw_take);
  assign aw_addr_nxt = aw_take ? s_axi_awaddr : aw_addr_r;
  assign w_hold_nxt = wr_fire ? 1'b0 : (w_hold_r || w_take);
  assign w_data_nxt = w_take ? s_axi_wdata : w_data_r;
  assign w_strb_nxt = w_take ? s_axi_wstrb : w_strb_r;
  assign bvalid_nxt = wr_fire ? 1'b1 : (bvalid_r && !s_axi_bready);
  assign bresp_nxt = wr_fire ? (wr_mapped ? oscc_pkg::OSCC_RESP_OKAY : oscc_pkg::OSCC_RESP_SLVERR) : bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Write channel state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= oscc_pkg::OSCC_RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and fail-safe state.

  logic [2:0] map_src;
  logic [3:0] map_div;
  logic map_32m;
  logic ost_done;

  // Changing the clock select field or an enabled external clock failure after start-up is seen here.
  wire logic scs_write = wr_en && wr_ctl &&
    (wr_byte[oscc_pkg::OSCC_CTL_SCS_LSB +: 2] != system_clock_select);
  wire logic fail_detect = config_failsafe_en && ost_done && ext_clock_failed;

  // Control register keeps its unimplemented bit at zero. [R7]
  assign ctl_nxt = (wr_en && wr_ctl) ? (wr_byte & oscc_pkg::OSCC_CTL_WMASK) : ctl_r;
  // Trim keeps only its six implemented bits. [R16]
  assign tune_nxt = (wr_en && wr_tune) ? (wr_byte & oscc_pkg::OSCC_TUNE_WMASK) : tune_r;
  // Hardware set wins over a software clear in the same cycle. [R18]
  assign fail_flag_nxt = fail_detect ? 1'b1 :
    ((wr_en && wr_fail) ? wr_byte[oscc_pkg::OSCC_FAIL_FLAG_BIT] : fail_flag_r);
  assign fail_ie_nxt = (wr_en && wr_fail) ? wr_byte[oscc_pkg::OSCC_FAIL_IE_BIT] : fail_ie_r;
  // Fail-safe holds until the select field is changed, which restarts the timer. [R18]
  assign failsafe_nxt = fail_detect ? 1'b1 : (scs_write ? 1'b0 : failsafe_r);

  // Control and configuration registers.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctl_r <= oscc_pkg::OSCC_CTL_RESET;
      tune_r <= oscc_pkg::OSCC_TUNE_RESET;
      fail_flag_r <= 1'b0;
      fail_ie_r <= 1'b0;
      failsafe_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      tune_r <= tune_nxt;
      fail_flag_r <= fail_flag_nxt;
      fail_ie_r <= fail_ie_nxt;
      failsafe_r <= failsafe_nxt;
    end
  end

  // Force bit overrides the software enable; otherwise the enable bit rules. [R1] [R2]
  assign pll_enable = config_pll_force | software_pll_enable;

  // Frequency decode of the internal select field. [R3] [R4] [R5]
  oscc_freq_map u_map
  (
    .ifs(internal_freq_select),
    .pll_on(software_pll_enable),
    .src(map_src),
    .div_log2(map_div),
    .pll_32m(map_32m)
  );

  // Start-up timer restarts on a clock select change; outside crystal modes it counts clk_sys cycles instead. [R20]
  oscc_ost u_ost
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .restart(scs_write),
    .ext_tick(ext_osc_tick || !config_crystal_mode),
    .done(ost_done)
  );

  // Config-word source is used only once the timer is done and no failure is latched. [R6] [R20]
  wire logic use_config = (system_clock_select == 2'b00) && ost_done && !failsafe_r;
  // Secondary oscillator selected by code 01 unless failed over. [R6]
  wire logic use_secondary = (system_clock_select == 2'b01) && !failsafe_r;
  // Fallback and code 1x both take the mapped internal source. [R6] [R19]
  wire logic [2:0] source_sel = use_config ? oscc_pkg::OSCC_SRC_CONFIG :
    (use_secondary ? oscc_pkg::OSCC_SRC_SECONDARY : map_src);

  // Registered clock control outputs.
  logic [2:0] src_r;
  logic [3:0] div_r;
  logic p32_r;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      src_r <= oscc_pkg::OSCC_SRC_MF;
      div_r <= 4'h0;
      p32_r <= 1'b0;
    end
    else
    begin
      src_r <= source_sel;
      div_r <= map_div;
      p32_r <= map_32m;
    end
  end
  assign clock_source = src_r;
  assign clock_div_log2 = div_r;
  assign pll_32m_select = p32_r;
  assign freq_trim = tune_r[5:0]; // Signed trim goes straight to the oscillator. [R16]
  assign osc_fail_irq = fail_flag_r && fail_ie_r; // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Status assembly: every flag is a live hardware condition.

  logic [7:0] status;
  assign status[oscc_pkg::OSCC_ST_SECONDARY_OSC_READY] = timer_osc_enable ? secondary_osc_ready : 1'b1; // [R8]
  assign status[oscc_pkg::OSCC_ST_PLL_READY_FLAG] = pll_locked; // [R9]
  assign status[oscc_pkg::OSCC_ST_STARTUP_TIMER_STATUS] = src_r == oscc_pkg::OSCC_SRC_CONFIG; // [R10]
  assign status[oscc_pkg::OSCC_ST_HFR] = high_freq_osc_ready; // [R11]
  assign status[oscc_pkg::OSCC_ST_HFL] = high_freq_within_2pct; // [R12]
  assign status[oscc_pkg::OSCC_ST_MFR] = mid_freq_osc_ready; // [R13]
  assign status[oscc_pkg::OSCC_ST_LFR] = low_freq_osc_ready; // [R14]
  assign status[oscc_pkg::OSCC_ST_HFS] = high_freq_within_half_pct; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one cycle from address to data.

  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  assign s_axi_arready = !rvalid_r;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic rd_ctl = s_axi_araddr == oscc_pkg::OSCC_ADDR_CONTROL;
  wire logic rd_sts = s_axi_araddr == oscc_pkg::OSCC_ADDR_STATUS;
  wire logic rd_tune = s_axi_araddr == oscc_pkg::OSCC_ADDR_TUNING;
  wire logic rd_fail = s_axi_araddr == oscc_pkg::OSCC_ADDR_FAIL;
  wire logic rd_mapped = rd_ctl || rd_sts || rd_tune || rd_fail;
  // Status reads are snapshots of live flags; writes to it change nothing. [R17]
  wire logic [7:0] rd_byte = rd_ctl ? ctl_r : rd_sts ? status : rd_tune ? tune_r :
    rd_fail ? {6'h00, fail_ie_r, fail_flag_r} : 8'h00;

  assign rvalid_nxt = ar_take ? 1'b1 : (rvalid_r && !s_axi_rready);
  assign rdata_nxt = ar_take ? {24'h00_0000, rd_byte} : rdata_r;
  assign rresp_nxt = ar_take ? (rd_mapped ? oscc_pkg::OSCC_RESP_OKAY : oscc_pkg::OSCC_RESP_SLVERR) : rresp_r;

  // Read channel state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= oscc_pkg::OSCC_RESP_OKAY;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule // oscc_ctrl

// File: test/oscc_assertions.sv
// Concurrent checks on the ports of the oscillator control block.
`timescale 1ns/10ps
module oscc_assertions
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Write channels.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator conditions.
  input wire logic config_pll_force,
  input wire logic timer_osc_enable,
  input wire logic secondary_osc_ready,
  input wire logic high_freq_within_2pct,
  input wire logic high_freq_within_half_pct,
  input wire logic mid_freq_osc_ready,
  input wire logic low_freq_osc_ready,
  // Controls.
  input wire logic pll_enable,
  input wire logic pll_32m_select
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire st_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == oscc_pkg::OSCC_ADDR_STATUS;
  wire ctl_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == oscc_pkg::OSCC_ADDR_CONTROL;

  // Handshake timing; the status flags are captured at address acceptance.
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_pll_force: assert property (config_pll_force |-> pll_enable) else $error("forced pll off");
  a_pll_32m: assert property (pll_32m_select |-> pll_enable || $past(pll_enable)) else $error("32m without pll");
  a_sec_ready: assert property (st_rd |=> s_axi_rdata[7] ==
    ($past(timer_osc_enable) ? $past(secondary_osc_ready) : 1'h1)) else $error("secondary ready wrong");
  a_hf_accuracy: assert property (st_rd |=> s_axi_rdata[3] == $past(high_freq_within_2pct)
    && s_axi_rdata[0] == $past(high_freq_within_half_pct)) else $error("hf accuracy wrong");
  a_low_mid: assert property (st_rd |=> s_axi_rdata[2:1] == $past({mid_freq_osc_ready, low_freq_osc_ready}))
    else $error("mf lf ready wrong");
  a_ctl_gap: assert property (ctl_rd |=> s_axi_rdata[2] == 1'b0) else $error("control bit 2 set");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
endmodule // oscc_assertions

bind oscc_ctrl oscc_assertions u_chk (.clk_sys, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .config_pll_force, .timer_osc_enable, .secondary_osc_ready, .high_freq_within_2pct,
  .high_freq_within_half_pct, .mid_freq_osc_ready, .low_freq_osc_ready, .pll_enable, .pll_32m_select);

// File: test/oscillator_control_status_bench.sv
// Register-level testbench for the oscillator control block.
`timescale 1ns/10ps
module oscillator_control_status_bench;
  logic clk_sys = 1'h0, srst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, clock_div_log2;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic config_pll_force = 1'h0, config_crystal_mode = 1'h0, config_failsafe_en = 1'h0, timer_osc_enable = 1'h0;
  logic secondary_osc_ready = 1'h0, pll_locked = 1'h0, high_freq_osc_ready = 1'h0, high_freq_within_2pct = 1'h0;
  logic high_freq_within_half_pct = 1'h0, mid_freq_osc_ready = 1'h0, low_freq_osc_ready = 1'h0;
  logic ext_osc_tick = 1'h0, ext_clock_failed = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_enable, pll_32m_select, osc_fail_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [2:0] clock_source;
  logic [5:0] freq_trim;
  logic [6:0] fm;
  logic [8:0] pats [3] = '{9'h05B, 9'h1A4, 9'h15B};
  int error_cnt = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // A 25 ns clock; the design sees every port driven by this bench.
  always #12.5 clk_sys = ~clk_sys;
  oscc_ctrl DUT (.clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_pll_force, .config_crystal_mode,
    .config_failsafe_en, .timer_osc_enable, .secondary_osc_ready, .pll_locked, .high_freq_osc_ready,
    .high_freq_within_2pct, .high_freq_within_half_pct, .mid_freq_osc_ready, .low_freq_osc_ready, .ext_osc_tick,
    .ext_clock_failed, .pll_enable, .clock_source, .clock_div_log2, .pll_32m_select, .freq_trim, .osc_fail_irq);

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks; readies are looked at on the falling edge, where they are settled.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bit ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(da && dw))
    begin
      @(negedge clk_sys);
      ta = s_axi_awready && !da;
      tw = s_axi_wready && !dw;
      @(posedge clk_sys);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
      da |= ta;
      dw |= tw;
    end
    // Bready already stands, so the response is taken at the first edge that shows it.
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'h1);
    chk("bresp", 32'(oscc_pkg::OSCC_RESP_OKAY), 32'(s_axi_bresp));
    @(posedge clk_sys);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'h1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'h1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'h0;
    chk(nm, e, rd_d);
    chk("rresp", 32'(oscc_pkg::OSCC_RESP_OKAY), 32'(rd_r));
  endtask

  // Expected source and divide for each frequency select code.
  function automatic logic [6:0] fmap(input logic [3:0] c);
    if (c[3])
      return {oscc_pkg::OSCC_SRC_HF, 4'hF - c};
    if (c[2])
      return {oscc_pkg::OSCC_SRC_MF, 4'h7 - c};
    if (c == 4'h3)
      return {oscc_pkg::OSCC_SRC_HF, 4'h9};
    if (c == 4'h2)
      return {oscc_pkg::OSCC_SRC_MF, 4'h4};
    return {oscc_pkg::OSCC_SRC_LF, 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the roughly 2250 cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'h0;
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'(oscc_pkg::OSCC_CTL_RESET), "control");
    rc(oscc_pkg::OSCC_ADDR_TUNING, 32'h0000_0000, "tuning");
    chk("source", 32'(oscc_pkg::OSCC_SRC_MF), 32'(clock_source));
    $display("test reset values done");
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'hFF);
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'h0000_00FB, "control");
    chk("pll", 32'h0000_0001, 32'(pll_enable));
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'hF2);
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'h0000_00F2, "control");
    chk("pll 32m", 32'h0000_0001, 32'(pll_32m_select));
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'h72);
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'h0000_0072, "control");
    chk("pll 32m", 32'h0000_0000, 32'(pll_32m_select));
    chk("pll", 32'h0000_0000, 32'(pll_enable));
    config_pll_force <= 1'h1;
    @(negedge clk_sys);
    chk("pll forced", 32'h0000_0001, 32'(pll_enable));
    @(posedge clk_sys);
    config_pll_force <= 1'h0;
    $display("test pll control done");
    for (int c = 0; c < 16; c++)
    begin
      fm = fmap(4'(c));
      wr(oscc_pkg::OSCC_ADDR_CONTROL, {1'h0, 4'(c), 3'h2});
      rc(oscc_pkg::OSCC_ADDR_CONTROL, {24'h00_0000, 1'h0, 4'(c), 3'h2}, "control");
      chk("source", 32'(fm[6:4]), 32'(clock_source));
      chk("divide", 32'(fm[3:0]), 32'(clock_div_log2));
    end
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'h39);
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'h0000_0039, "control");
    chk("source", 32'(oscc_pkg::OSCC_SRC_SECONDARY), 32'(clock_source));
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'h3B);
    rc(oscc_pkg::OSCC_ADDR_CONTROL, 32'h0000_003B, "control");
    chk("source", 32'(oscc_pkg::OSCC_SRC_MF), 32'(clock_source));
    $display("test frequency map done");
    // The patterns drive every flag both ways; bit 5 stays clear while internal.
    foreach (pats[i])
    begin
      {timer_osc_enable, secondary_osc_ready, pll_locked} <= pats[i][8:6];
      {high_freq_osc_ready, high_freq_within_2pct, mid_freq_osc_ready} <= pats[i][4:2];
      {low_freq_osc_ready, high_freq_within_half_pct} <= pats[i][1:0];
      wr(oscc_pkg::OSCC_ADDR_STATUS, ~pats[i][7:0]);
      rc(oscc_pkg::OSCC_ADDR_STATUS, {24'h00_0000, pats[i][8] ? pats[i][7] : 1'h1, pats[i][6], 1'h0, pats[i][4:0]},
        "status");
    end
    $display("test status done");
    foreach (pats[i])
    begin
      wr(oscc_pkg::OSCC_ADDR_TUNING, pats[i][7:0] ^ 8'hC4);
      rc(oscc_pkg::OSCC_ADDR_TUNING, 32'(pats[i][5:0] ^ 6'h04), "tuning");
      chk("trim", 32'(pats[i][5:0] ^ 6'h04), 32'(freq_trim));
    end
    $display("test trim done");
    wr(oscc_pkg::OSCC_ADDR_FAIL, 8'h02);
    config_crystal_mode <= 1'h1;
    wr(oscc_pkg::OSCC_ADDR_CONTROL, 8'h68);
    repeat (1023)
    begin
      @(posedge clk_sys);
      ext_osc_tick <= 1'h1;
      @(posedge clk_sys);
      ext_osc_tick <= 1'h0;
    end
    rc(oscc_pkg::OSCC_ADDR_STATUS, 32'h0000_005B, "status");
    @(posedge clk_sys);
    ext_osc_tick <= 1'h1;
    @(posedge clk_sys);
    ext_osc_tick <= 1'h0;
    rc(oscc_pkg::OSCC_ADDR_STATUS, 32'h0000_007B, "status");
    chk("source", 32'(oscc_pkg::OSCC_SRC_CONFIG), 32'(clock_source));
    config_failsafe_en <= 1'h1;
    ext_clock_failed <= 1'h1;
    rc(oscc_pkg::OSCC_ADDR_FAIL, 32'h0000_0003, "fail");
    chk("source", 32'(oscc_pkg::OSCC_SRC_HF), 32'(clock_source));
    chk("divide", 32'h0000_0002, 32'(clock_div_log2));
    chk("irq", 32'h0000_0001, 32'(osc_fail_irq));
    ext_clock_failed <= 1'h0;
    wr(oscc_pkg::OSCC_ADDR_FAIL, 8'h00);
    rc(oscc_pkg::OSCC_ADDR_FAIL, 32'h0000_0000, "fail");
    ext_clock_failed <= 1'h1;
    rc(oscc_pkg::OSCC_ADDR_FAIL, 32'h0000_0001, "fail");
    chk("irq masked", 32'h0000_0000, 32'(osc_fail_irq));
    $display("test start-up and failure done");
    complete_run();
  end
endmodule // oscillator_control_status_bench
